// ---- src/ufs_params.svh ----
`ifndef UFS_PARAMS_SVH
`define UFS_PARAMS_SVH
// Register offsets (byte addresses; printed offset 0xD2 kept as index).
`define UFS_LOW_IDX        8'hD2
`define UFS_LOW_ADDR       10'h348
`define UFS_HIGH_ADDR      10'h34C
`define UFS_IRQ_STAT_ADDR  10'h350
`define UFS_IRQ_MASK_ADDR  10'h354
// High register field positions.
`define UFS_HI_VALID_BIT   7
`define UFS_HI_ANY_FRAME_START_FLAG_BIT    6
`define UFS_HI_IE_BIT      5
`define UFS_HI_LOCK_BIT    4
`define UFS_HI_DIS_BIT     3
// Reset values.
`define UFS_LOW_RST        8'h00
`define UFS_HIGH_RST       8'h00
// Interrupt status bits: 0 any frame start, 1 real token, 2 artificial start.
`define UFS_IRQ_W          3
`define UFS_IRQ_RST        3'h0
// Pulse timing: eight core clock periods at 10 ns.
`define UFS_CLK_NS         10
`define UFS_PULSE_NS       80
`define UFS_PULSE_CYC      ((`UFS_PULSE_NS + `UFS_CLK_NS - 1) / `UFS_CLK_NS)
`define UFS_CNT_W          4
`endif

// ---- src/ufs_pkg.sv ----
package ufs_pkg;
    // Wishbone request as seen by the slave.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [9:0]  adr;
        logic [31:0] dat;
    } ufs_wb_req_t;
    // Frame start token from the receive logic.
    typedef struct packed {
        logic        tok;
        logic        art;
        logic [10:0] num;
    } ufs_frame_t;
    // Pulse generator states, Gray along idle-low-idle.
    typedef enum logic [0:0] {
        UFS_IDLE = 1'b0,
        UFS_LOW  = 1'b1
    } ufs_pulse_st_t;
endpackage : ufs_pkg

// ---- src/ufs_pulse.sv ----
`timescale 1ns/10ps
`include "ufs_params.svh"
module ufs_pulse (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Control.
    input  wire logic trig_i,
    input  wire logic dis_i,
    // Pin.
    output logic      pin_n_o
);
    import ufs_pkg::*;

    ufs_pulse_st_t           st_ff, nxt_st;
    logic [`UFS_CNT_W-1:0]   cnt_ff, nxt_cnt;
    logic                    pin_n_ff, nxt_pin_n;

    // A trigger during an active pulse restarts it so no frame start is dropped.
    always_comb begin
        nxt_st    = st_ff;
        nxt_cnt   = cnt_ff;
        nxt_pin_n = 1'b1;
        if (dis_i) begin
            nxt_st  = UFS_IDLE;
            nxt_cnt = '0;
        end else if (trig_i) begin
            nxt_st    = UFS_LOW;
            nxt_cnt   = `UFS_CNT_W'(`UFS_PULSE_CYC - 1);
            nxt_pin_n = 1'b0;
        end else begin
            unique case (st_ff)
                UFS_IDLE: begin
                    nxt_pin_n = 1'b1;
                end
                UFS_LOW: begin
                    if (cnt_ff == '0) begin
                        nxt_st    = UFS_IDLE;
                        nxt_pin_n = 1'b1;
                    end else begin
                        nxt_cnt   = cnt_ff - `UFS_CNT_W'(1);
                        nxt_pin_n = 1'b0;
                    end
                end
            endcase
        end
    end

    // Registered pin keeps the output glitch free.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff    <= UFS_IDLE;
            cnt_ff   <= '0;
            pin_n_ff <= 1'b1;
        end else if (ce_i) begin
            st_ff    <= nxt_st;
            cnt_ff   <= nxt_cnt;
            pin_n_ff <= nxt_pin_n;
        end
    end

    assign pin_n_o = pin_n_ff | dis_i;

    // Disabling mid-pulse cuts the pulse on purpose, so the width check stands down then.
    property p_width;
        @(posedge clk_i) disable iff (rst_i || dis_i)
        ($fell(pin_n_o) && ce_i) |-> (!pin_n_o) [*8];
    endproperty
    a_width: assert property (p_width)
        else $error("frame pulse shorter than eight cycles");

    // The pin stays high for as long as the disable bit is set.
    property p_dis_high;
        @(posedge clk_i) disable iff (rst_i)
        dis_i |-> pin_n_o;
    endproperty
    a_dis_high: assert property (p_dis_high)
        else $error("pin low while pulse disabled");
endmodule : ufs_pulse

// ---- src/ufs_capture.sv ----
`timescale 1ns/10ps
`include "ufs_params.svh"
module ufs_capture (
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // Frame events.
    input  wire ufs_pkg::ufs_frame_t frame_i,
    // Captured number.
    output logic [10:0]            num_o,
    output logic                   valid_o
);
    import ufs_pkg::*;

    logic [10:0] num_ff, nxt_num;
    logic        valid_ff, nxt_valid;

    // Both bytes load in one cycle from the same token; a real token wins over an artificial one.
    always_comb begin
        nxt_num   = num_ff;
        nxt_valid = valid_ff;
        if (frame_i.tok) begin
            nxt_num   = frame_i.num;
            nxt_valid = 1'b1;
        end else if (frame_i.art) begin
            nxt_valid = 1'b0;
        end
    end

    // Number and valid flag register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            num_ff   <= 11'h000;
            valid_ff <= 1'b0;
        end else if (ce_i) begin
            num_ff   <= nxt_num;
            valid_ff <= nxt_valid;
        end
    end

    assign num_o   = num_ff;
    assign valid_o = valid_ff;

    // A token loads all eleven bits and the valid flag in one edge.
    property p_cap;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && frame_i.tok) |=> (num_o == $past(frame_i.num) && valid_o);
    endproperty
    a_cap: assert property (p_cap)
        else $error("frame number not captured whole");

    // An artificial start alone drops the valid flag.
    property p_art;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && frame_i.art && !frame_i.tok) |=> !valid_o;
    endproperty
    a_art: assert property (p_art)
        else $error("valid not cleared by artificial start");
endmodule : ufs_capture

// ---- src/ufs_top.sv ----
// What this block does
// - Disabled pulse: no low pulse on frame start.
// - Disabled pulse holds the pin high.
// - Each frame start drives pin low eight cycles.
// - High register bits 2:0 hold frame bits 10:8.
// - Low register holds bits 7:0, resets zero.
// - Token sets valid, artificial start clears it.
// - Frame starts set flag; firmware set pulses too.
// - Flag with enable and channel raises interrupt.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "ufs_params.svh"
module ufs_top (
    // Clock, reset and enable.
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    // Wishbone slave.
    input  wire ufs_pkg::ufs_wb_req_t  wb_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    // Frame events from the receive logic and the frame timer.
    input  wire ufs_pkg::ufs_frame_t   frame_i,
    input  wire logic                  timer_locked_i,
    input  wire logic                  irq_chan_en_i,
    // Outputs.
    output logic                       frame_pin_n_o,
    output logic                       frame_irq_o,
    output logic                       irq_o
);
    import ufs_pkg::*;

    logic [10:0]              num;
    logic                     valid;
    logic                     any_frame_start_flag_ff, nxt_any_frame_start_flag;
    logic                     ie_ff, nxt_ie;
    logic                     dis_ff, nxt_dis;
    logic [`UFS_IRQ_W-1:0]    stat_ff, nxt_stat;
    logic [`UFS_IRQ_W-1:0]    mask_ff, nxt_mask;
    logic                     ack_ff, nxt_ack;
    logic [31:0]              rdat_ff, nxt_rdat;
    logic                     req;
    logic                     wr;
    logic                     wr_hi;
    logic                     fw_set;
    logic                     hw_set;
    logic                     trig;
    logic [7:0]               hi_byte;
    logic [`UFS_IRQ_W-1:0]    ev;

    // Frame number capture.
    ufs_capture u_cap (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .frame_i (frame_i),
        .num_o   (num),
        .valid_o (valid)
    );

    // Active-low frame start pin.
    ufs_pulse u_pulse (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .trig_i  (trig),
        .dis_i   (dis_ff),
        .pin_n_o (frame_pin_n_o)
    );

    // Bus decode; ack each request once, one cycle after it is seen.
    assign req   = wb_i.cyc & wb_i.stb & ~ack_ff;
    assign wr    = req & wb_i.we & wb_i.sel[0];
    assign wr_hi = wr & (wb_i.adr == `UFS_HIGH_ADDR);

    // Firmware writing a one to the flag while it is clear acts like a hardware frame start.
    assign hw_set = frame_i.tok | frame_i.art;
    assign fw_set = wr_hi & wb_i.dat[`UFS_HI_ANY_FRAME_START_FLAG_BIT] & ~any_frame_start_flag_ff;
    assign trig   = ce_i & ((hw_set & ~any_frame_start_flag_ff) | fw_set | (hw_set & any_frame_start_flag_ff));

    // High register image, valid and lock status come live from hardware.
    always_comb begin
        hi_byte = 8'h00;
        hi_byte[`UFS_HI_VALID_BIT] = valid;
        hi_byte[`UFS_HI_ANY_FRAME_START_FLAG_BIT]  = any_frame_start_flag_ff;
        hi_byte[`UFS_HI_IE_BIT]    = ie_ff;
        hi_byte[`UFS_HI_LOCK_BIT]  = timer_locked_i;
        hi_byte[`UFS_HI_DIS_BIT]   = dis_ff;
        hi_byte[2:0]               = num[10:8];
    end

    // Status events: any start, real token, artificial start.
    assign ev = {frame_i.art, frame_i.tok, hw_set | fw_set};

    // Control bits, flags and read data.
    always_comb begin
        nxt_any_frame_start_flag = any_frame_start_flag_ff;
        nxt_ie   = ie_ff;
        nxt_dis  = dis_ff;
        nxt_mask = mask_ff;
        nxt_stat = stat_ff;
        nxt_ack  = 1'b0;
        nxt_rdat = 32'h0000_0000;
        if (wr_hi) begin
            nxt_any_frame_start_flag = wb_i.dat[`UFS_HI_ANY_FRAME_START_FLAG_BIT];
            nxt_ie   = wb_i.dat[`UFS_HI_IE_BIT];
            nxt_dis  = wb_i.dat[`UFS_HI_DIS_BIT];
        end
        if (wr && wb_i.adr == `UFS_IRQ_MASK_ADDR) begin
            nxt_mask = wb_i.dat[`UFS_IRQ_W-1:0];
        end
        if (wr && wb_i.adr == `UFS_IRQ_STAT_ADDR) begin
            nxt_stat = stat_ff & ~wb_i.dat[`UFS_IRQ_W-1:0];
        end
        // Set wins over a clear in the same cycle.
        if (hw_set) begin
            nxt_any_frame_start_flag = 1'b1;
        end
        nxt_stat = nxt_stat | ev;
        if (req) begin
            nxt_ack = 1'b1;
            unique case (wb_i.adr)
                `UFS_LOW_ADDR:      nxt_rdat = {24'h000000, num[7:0]};
                `UFS_HIGH_ADDR:     nxt_rdat = {24'h000000, hi_byte};
                `UFS_IRQ_STAT_ADDR: nxt_rdat = {29'h0000_0000, stat_ff};
                `UFS_IRQ_MASK_ADDR: nxt_rdat = {29'h0000_0000, mask_ff};
                default:            nxt_rdat = 32'h0000_0000;
            endcase
        end
    end

    // Register bank; the clock enable freezes the bus answer too.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            any_frame_start_flag_ff <= 1'b0;
            ie_ff   <= 1'b0;
            dis_ff  <= 1'b0;
            stat_ff <= `UFS_IRQ_RST;
            mask_ff <= `UFS_IRQ_RST;
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            any_frame_start_flag_ff <= nxt_any_frame_start_flag;
            ie_ff   <= nxt_ie;
            dis_ff  <= nxt_dis;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            ack_ff  <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_ack_o    = ack_ff;
    assign wb_dat_o    = rdat_ff;
    // The enable bit is only read here, never written by hardware.
    assign frame_irq_o = any_frame_start_flag_ff & ie_ff & irq_chan_en_i;
    assign irq_o       = |(stat_ff & mask_ff);

    // Frame interrupt follows flag, enable bit and channel enable.
    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        frame_irq_o == (any_frame_start_flag_ff && ie_ff && irq_chan_en_i);
    endproperty
    a_irq: assert property (p_irq)
        else $error("frame interrupt mismatch");

    // Only a firmware write may move the enable bit.
    property p_ie_hold;
        @(posedge clk_i) disable iff (rst_i)
        !wr_hi |=> $stable(ie_ff);
    endproperty
    a_ie_hold: assert property (p_ie_hold)
        else $error("enable bit changed without a write");

    // Every frame start leaves the flag set.
    property p_set;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && hw_set) |=> any_frame_start_flag_ff;
    endproperty
    a_set: assert property (p_set)
        else $error("flag not set by frame start");

    // An enabled frame start pulls the pin low on the next edge.
    property p_pulse;
        @(posedge clk_i) disable iff (rst_i)
        (trig && !dis_ff && !nxt_dis) |=> !frame_pin_n_o;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("no pulse after frame start");

    // A pulse suppressed while disabled must not show up once the bit clears.
    property p_nopulse;
        @(posedge clk_i) disable iff (rst_i)
        $fell(dis_ff) |-> frame_pin_n_o;
    endproperty
    a_nopulse: assert property (p_nopulse)
        else $error("pulse while disabled");

    // Read data carries the number as it stood when the request was taken.
    property p_low;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && req && wb_i.adr == `UFS_LOW_ADDR) |=> (wb_dat_o[7:0] == $past(num[7:0]));
    endproperty
    a_low: assert property (p_low)
        else $error("low register read wrong");

    // Upper number bits sit in bits 2:0 of the high register.
    property p_high;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && req && wb_i.adr == `UFS_HIGH_ADDR) |=> (wb_dat_o[2:0] == $past(num[10:8]));
    endproperty
    a_high: assert property (p_high)
        else $error("high register bits wrong");
endmodule : ufs_top

// ---- dv/ufs_host_model.sv ----
`timescale 1ns/10ps
module ufs_host_model (
    // Clock.
    input  wire logic           clk_i,
    // Frame starts toward the block.
    output ufs_pkg::ufs_frame_t frame_o
);
    import ufs_pkg::*;

    logic [10:0] last_num;

    // Idle at time zero, no start pending.
    initial begin
        frame_o = '0;
        last_num = 11'h000;
    end

    // One start per call; the number lines carry junk outside it, so a stale value never passes.
    task automatic send(input logic art, input logic [10:0] num);
        @(posedge clk_i);
        frame_o <= '{tok: !art, art: art, num: num};
        last_num = num;
        @(posedge clk_i);
        frame_o <= '{tok: 1'b0, art: 1'b0, num: ~last_num};
    endtask
endmodule // ufs_host_model

// ---- dv/ufs_top_test.sv ----
`timescale 1ns/10ps
`include "ufs_params.svh"
module ufs_top_test;
    import ufs_pkg::*;

    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    ufs_wb_req_t wb_req  = '0;
    logic        locked  = 1'b0;
    logic        chan_en = 1'b0;
    logic        ce      = 1'b1;
    ufs_frame_t  frame;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        pin_n;
    logic        f_irq;
    logic        irq_o;
    logic [31:0] rd;
    int          len;
    int          err_total = 0;
    int          n_tests   = 0;
    int          cycles    = 0;

    // Clock enable is driven so that one scenario can freeze the block.
    ufs_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_i(frame),
        .timer_locked_i(locked), .irq_chan_en_i(chan_en), .frame_pin_n_o(pin_n),
        .frame_irq_o(f_irq), .irq_o(irq_o));
    ufs_host_model host_u (.clk_i(clk_i), .frame_o(frame));

    // Free running clock.
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Hang guard.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            stop_test();
        end
    end

    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Compares and reports.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Samples an output at the next edge: 0 pin, 1 frame interrupt, 2 interrupt.
    // The output is read after the wait, so a value copied at call time never slips in.
    task automatic probe(input int sel, input logic e);
        logic v;
        @(posedge clk_i);
        v = (sel == 0) ? pin_n : ((sel == 1) ? f_irq : irq_o);
        check({31'h0, v}, {31'h0, e});
    endtask

    // Classic single cycle; waits for ack however long it takes.
    task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d);
        wb_req <= '{1'b1, 1'b1, we, 4'hF, a, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        wb_req <= '0;
        @(posedge clk_i);
    endtask

    // Waits up to 20 cycles for a low pulse and counts its length.
    task automatic pulse_len(output int n);
        int w;
        n = 0;
        for (w = 0; w < 20; w++) begin
            @(posedge clk_i);
            if (pin_n === 1'b0) break;
        end
        while (pin_n === 1'b0 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // Reset values and an unmapped address.
    task automatic t_reset();
        wb(1'b0, `UFS_LOW_ADDR, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, `UFS_HIGH_ADDR, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, 10'h3FC, 32'h0);
        check(rd, 32'h0);
        probe(0, 1'b1);
    endtask

    // A real token loads both number parts and pulses the pin.
    task automatic t_token();
        locked <= 1'b1;
        fork
            host_u.send(1'b0, 11'h5A3);
            pulse_len(len);
        join
        check(len, 32'd8);
        wb(1'b0, `UFS_HIGH_ADDR, 32'h0);
        check(rd, 32'hD5);
        wb(1'b0, `UFS_LOW_ADDR, 32'h0);
        check(rd, 32'hA3);
        probe(1, 1'b0);
    endtask

    // An artificial start clears valid, keeps the number, still pulses.
    task automatic t_art();
        fork
            host_u.send(1'b1, 11'h2FF);
            pulse_len(len);
        join
        check(len, 32'd8);
        wb(1'b0, `UFS_HIGH_ADDR, 32'h0);
        check(rd, 32'h55);
    endtask

    // Sticky status, mask and write-one-to-clear.
    task automatic t_irq();
        wb(1'b0, `UFS_IRQ_STAT_ADDR, 32'h0);
        check(rd, 32'h7);
        probe(2, 1'b0);
        wb(1'b1, `UFS_IRQ_MASK_ADDR, 32'h1);
        probe(2, 1'b1);
        wb(1'b1, `UFS_IRQ_STAT_ADDR, 32'h1);
        probe(2, 1'b0);
        wb(1'b0, `UFS_IRQ_STAT_ADDR, 32'h0);
        check(rd, 32'h6);
    endtask

    // Firmware clears and sets the flag; the set pulses and interrupts.
    task automatic t_flag();
        chan_en <= 1'b1;
        wb(1'b1, `UFS_HIGH_ADDR, 32'h20);
        probe(1, 1'b0);
        fork
            wb(1'b1, `UFS_HIGH_ADDR, 32'h60);
            pulse_len(len);
        join
        check(len, 32'd8);
        probe(1, 1'b1);
        chan_en <= 1'b0;
        probe(1, 1'b0);
    endtask

    // Disabled pulse keeps the pin high through a token.
    task automatic t_dis();
        wb(1'b1, `UFS_HIGH_ADDR, 32'h08);
        fork
            host_u.send(1'b0, 11'h7FF);
            pulse_len(len);
        join
        check(len, 32'd0);
        probe(0, 1'b1);
        wb(1'b0, `UFS_HIGH_ADDR, 32'h0);
        check(rd, 32'hDF);
        wb(1'b0, `UFS_LOW_ADDR, 32'h0);
        check(rd, 32'hFF);
        wb(1'b1, `UFS_HIGH_ADDR, 32'h00);
        probe(0, 1'b1);
    endtask

    // Clock enable low freezes the block: a token is lost and the pin stays high.
    task automatic t_hold();
        ce <= 1'b0;
        fork
            host_u.send(1'b0, 11'h123);
            pulse_len(len);
        join
        check(len, 32'd0);
        ce <= 1'b1;
        wb(1'b0, `UFS_LOW_ADDR, 32'h0);
        check(rd, 32'hFF);
    endtask

    // Main sequence.
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_token();
        t_art();
        t_irq();
        t_flag();
        t_dis();
        t_hold();
        stop_test();
    end
endmodule // ufs_top_test
